// ---- rtl/pcc_config_regs.sv ----
// What this block does
// - Identity codes come from the EEPROM, else from built-in defaults.
// - Option clear: command bit 9 reads zero, no fast back-to-back issued.
// - Option set: command bit 9 read/write, reset zero, picks agent scope.
// - Command bit 8 set: address parity error drives system error out.
// - Command bit 6 set: target drives parity line, master samples it.
// - Command bit 6 clear: data parity errors neither drive the parity line nor set status bit 8; resets clear.
// - Command bits 7,5,4,3 read zero; no stepping, special cycles ignored.
// - Command bit 2 gates all master transactions.
// - Command bit 1 gates claiming memory cycles.
// - Command bit 0 gates claiming I/O cycles.
// - Status reads show live flags; writing one clears, never sets.
// - Status bit 15 sets on any detected parity error.
// - Status bit 14 sets when system error out is asserted.
// - Status bit 13 sets on received master abort.
// - Status bit 12 sets on received target abort.
// - Status bit 11 sets when the device signals target abort.
// - Status bits 10-9 read 01b; device select four clocks after frame.
// - Status bit 8 sets on parity line while master with parity enable.
// - Status bit 7 mirrors the fast back-to-back option, read only.
// - Status bit 4 mirrors power option; bits 6,5 read zero.
// - Programming interface reads 00h; revision reads the REVISION_VAL parameter.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_config_regs #(
  parameter logic [15:0] DEF_VENDOR   = 16'h1234, // Arbitrary neutral value.
  parameter logic [15:0] DEF_DEVICE   = 16'h5678, // Arbitrary neutral value.
  parameter logic [7:0]  REVISION_VAL = 8'h00     // Arbitrary neutral value.
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               cfg_sel,
  input  wire logic               cfg_wr,
  input  wire logic [7:0]         cfg_addr,
  input  wire pcc_pkg::pcc_lane_t cfg_be,
  input  wire logic [31:0]        cfg_wdata,
  output logic [31:0]             cfg_rdata,
  input  wire logic               ee_present,
  input  wire logic               ee_valid,
  input  wire pcc_pkg::pcc_word_t ee_vendor,
  input  wire pcc_pkg::pcc_word_t ee_device,
  input  wire logic               opt_fb2b,
  input  wire logic               opt_pm,
  input  wire logic               cycle_frame_n,
  input  wire logic               claim_hit,
  output logic                    device_select_out_n,
  input  wire logic               addr_parity_err,
  input  wire logic               data_parity_err,
  input  wire logic               is_target,
  input  wire logic               is_master,
  input  wire logic               parity_error_line_n,
  output logic                    parity_error_out_n,
  output logic                    parity_error_out_oe,
  output logic                    system_error_out_n,
  output logic                    system_error_out_oe,
  input  wire logic               master_abort_evt,
  input  wire logic               target_abort_rx_evt,
  input  wire logic               target_abort_tx_evt,
  input  wire logic               io_cycle,
  input  wire logic               mem_cycle,
  output logic                    io_claim,
  output logic                    mem_claim,
  output logic                    master_enable,
  output logic                    fast_b2b_allowed,
  output logic                    fast_b2b_any_agent
);
  import pcc_pkg::*;

  pcc_word_t   vendor_identity_q;
  pcc_word_t   device_identity_q;
  pcc_word_t   cycle_ctrl_q;
  pcc_word_t   flags_q;
  pcc_word_t   flags_d;
  pcc_word_t   cmd_rd;
  pcc_word_t   flags_rd;
  pcc_word_t   hi_wdata;
  pcc_word_t   flag_clr;
  pcc_word_t   flag_set;
  pcc_decode_e dec_q;
  logic        frame_s1_q;
  logic        frame_s2_q;
  logic        perr_s1_q;
  logic        perr_s2_q;
  logic        fb2b_s1_q;
  logic        fb2b_s2_q;
  logic        pm_s1_q;
  logic        pm_s2_q;
  logic        ee_p_s1_q;
  logic        ee_p_s2_q;
  logic        ee_v_s1_q;
  logic        ee_v_s2_q;
  logic        id_loaded_q;
  logic        serr_q;
  logic        perr_q;
  logic        wr_ctrl;
  logic        wr_flags;

  // Pin inputs pass two flops; only the second stage is read by logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_s1_q <= 1'b1;
      frame_s2_q <= 1'b1;
      perr_s1_q  <= 1'b1;
      perr_s2_q  <= 1'b1;
      fb2b_s1_q  <= 1'b0;
      fb2b_s2_q  <= 1'b0;
      pm_s1_q    <= 1'b0;
      pm_s2_q    <= 1'b0;
      ee_p_s1_q  <= 1'b0;
      ee_p_s2_q  <= 1'b0;
      ee_v_s1_q  <= 1'b0;
      ee_v_s2_q  <= 1'b0;
    end else begin
      frame_s1_q <= cycle_frame_n;
      frame_s2_q <= frame_s1_q;
      perr_s1_q  <= parity_error_line_n;
      perr_s2_q  <= perr_s1_q;
      fb2b_s1_q  <= opt_fb2b;
      fb2b_s2_q  <= fb2b_s1_q;
      pm_s1_q    <= opt_pm;
      pm_s2_q    <= pm_s1_q;
      ee_p_s1_q  <= ee_present;
      ee_p_s2_q  <= ee_p_s1_q;
      ee_v_s1_q  <= ee_valid;
      ee_v_s2_q  <= ee_v_s1_q;
    end
  end

  // Identity words: defaults at reset, replaced once when the EEPROM load is done.
  // Only a fitted EEPROM may overwrite them, so a floating loader is harmless.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vendor_identity_q <= DEF_VENDOR;
      device_identity_q <= DEF_DEVICE;
      id_loaded_q       <= 1'b0;
    end else if (!id_loaded_q && ee_p_s2_q && ee_v_s2_q) begin
      vendor_identity_q <= ee_vendor;
      device_identity_q <= ee_device;
      id_loaded_q       <= 1'b1;
    end
  end

  // Write strobes; the status word sits in the upper half of dword 04h.
  assign wr_ctrl  = cfg_sel && cfg_wr && (cfg_addr[7:2] == 6'(`PCC_OFS_CONTROL >> 2));
  assign wr_flags = wr_ctrl;
  assign hi_wdata = cfg_wdata[31:16];

  // Command register; only implemented bits are ever stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle_ctrl_q <= `PCC_CMD_RESET;
    end else if (wr_ctrl) begin
      if (cfg_be[0]) begin
        cycle_ctrl_q[`PCC_CMD_IO]  <= cfg_wdata[`PCC_CMD_IO];
        cycle_ctrl_q[`PCC_CMD_MEM] <= cfg_wdata[`PCC_CMD_MEM];
        cycle_ctrl_q[`PCC_CMD_MST] <= cfg_wdata[`PCC_CMD_MST];
        cycle_ctrl_q[`PCC_CMD_PAR] <= cfg_wdata[`PCC_CMD_PAR];
      end
      if (cfg_be[1]) begin
        cycle_ctrl_q[`PCC_CMD_SERR] <= cfg_wdata[`PCC_CMD_SERR];
        // Writes to bit 9 land only while the option is on.
        if (fb2b_s2_q) begin
          cycle_ctrl_q[`PCC_CMD_FB2B] <= cfg_wdata[`PCC_CMD_FB2B];
        end
      end
    end
  end

  // Readback masks bit 9 by the option so a dropped option hides a stale one.
  always_comb begin
    cmd_rd = 16'h0000;
    cmd_rd[`PCC_CMD_IO]   = cycle_ctrl_q[`PCC_CMD_IO];
    cmd_rd[`PCC_CMD_MEM]  = cycle_ctrl_q[`PCC_CMD_MEM];
    cmd_rd[`PCC_CMD_MST]  = cycle_ctrl_q[`PCC_CMD_MST];
    cmd_rd[`PCC_CMD_PAR]  = cycle_ctrl_q[`PCC_CMD_PAR];
    cmd_rd[`PCC_CMD_SERR] = cycle_ctrl_q[`PCC_CMD_SERR];
    cmd_rd[`PCC_CMD_FB2B] = cycle_ctrl_q[`PCC_CMD_FB2B] & fb2b_s2_q;
  end

  // Gating outputs to the rest of the controller.
  assign io_claim           = io_cycle && cycle_ctrl_q[`PCC_CMD_IO];
  assign mem_claim          = mem_cycle && cycle_ctrl_q[`PCC_CMD_MEM];
  assign master_enable      = cycle_ctrl_q[`PCC_CMD_MST];
  assign fast_b2b_allowed   = fb2b_s2_q;
  assign fast_b2b_any_agent = fb2b_s2_q && cycle_ctrl_q[`PCC_CMD_FB2B];

  // Error pin drivers, one clock per detection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serr_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      serr_q <= addr_parity_err && cycle_ctrl_q[`PCC_CMD_SERR];
      perr_q <= data_parity_err && is_target && cycle_ctrl_q[`PCC_CMD_PAR];
    end
  end

  // Both pins are open drain: pull low while asserted, otherwise released.
  assign system_error_out_n  = 1'b0;
  assign system_error_out_oe = serr_q;
  assign parity_error_out_n  = 1'b0;
  assign parity_error_out_oe = perr_q;

  // Hardware events that set status flags.
  always_comb begin
    flag_set = 16'h0000;
    flag_set[`PCC_ST_DPE] = addr_parity_err || data_parity_err;
    flag_set[`PCC_ST_SSE] = serr_q;
    flag_set[`PCC_ST_RMA] = master_abort_evt;
    flag_set[`PCC_ST_RTA] = target_abort_rx_evt;
    flag_set[`PCC_ST_STA] = target_abort_tx_evt;
    flag_set[`PCC_ST_MDP] = is_master && cycle_ctrl_q[`PCC_CMD_PAR]
                            && (!perr_s2_q || perr_q);
  end

  // Write-one-to-clear mask on the sticky flags, byte lanes respected.
  // All sticky flags sit in the upper status byte, so only lane 3 clears them.
  always_comb begin
    flag_clr = 16'h0000;
    if (wr_flags) begin
      if (cfg_be[3]) begin
        flag_clr[15:11]       = hi_wdata[15:11];
        flag_clr[`PCC_ST_MDP] = hi_wdata[`PCC_ST_MDP];
      end
    end
  end

  // Set wins over a simultaneous clear so no event is lost.
  always_comb begin
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= `PCC_ST_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Live status view with fixed and mirrored bits.
  always_comb begin
    flags_rd = 16'h0000;
    flags_rd[15:11]      = flags_q[15:11];
    flags_rd[`PCC_ST_MDP] = flags_q[`PCC_ST_MDP];
    flags_rd[`PCC_ST_DT1:`PCC_ST_DT0] = `PCC_DT_MEDIUM;
    flags_rd[`PCC_ST_FB2B] = fb2b_s2_q;
    flags_rd[`PCC_ST_CAP]  = pm_s2_q;
  end

  // Medium decode: device select goes low four clocks after frame falls.
  // The device never claims special cycles; the decoder keeps them off claim_hit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_q <= PCC_IDLE;
    end else begin
      case (dec_q)
        PCC_IDLE: begin
          if (!frame_s2_q) begin
            dec_q <= PCC_WAIT;
          end
        end
        PCC_WAIT: begin
          dec_q <= claim_hit ? PCC_SEL : PCC_IDLE;
        end
        PCC_SEL: begin
          if (frame_s2_q) begin
            dec_q <= PCC_IDLE;
          end
        end
        default: begin
          dec_q <= PCC_IDLE;
        end
      endcase
    end
  end

  assign device_select_out_n = (dec_q != PCC_SEL);

  // Read data, registered; unmapped dwords read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_sel && !cfg_wr) begin
      case (cfg_addr[7:2])
        6'h00: begin
          cfg_rdata <= {device_identity_q, vendor_identity_q};
        end
        6'h01: begin
          cfg_rdata <= {flags_rd, cmd_rd};
        end
        6'h02: begin
          cfg_rdata <= {16'h0000, `PCC_PROGIF_VAL, REVISION_VAL};
        end
        default: begin
          cfg_rdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule

// ---- rtl/pcc_params.svh ----
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// Configuration byte offsets of the identity, control and status registers.
`define PCC_OFS_VENDOR   8'h00
`define PCC_OFS_DEVICE   8'h02
`define PCC_OFS_CONTROL  8'h04
`define PCC_OFS_FLAGS    8'h06
`define PCC_OFS_REVISION 8'h08
`define PCC_OFS_PROGIF   8'h09

// Command field positions.
`define PCC_CMD_IO   0
`define PCC_CMD_MEM  1
`define PCC_CMD_MST  2
`define PCC_CMD_PAR  6
`define PCC_CMD_SERR 8
`define PCC_CMD_FB2B 9

// Status field positions.
`define PCC_ST_CAP   4
`define PCC_ST_FB2B  7
`define PCC_ST_MDP   8
`define PCC_ST_DT0   9
`define PCC_ST_DT1   10
`define PCC_ST_STA   11
`define PCC_ST_RTA   12
`define PCC_ST_RMA   13
`define PCC_ST_SSE   14
`define PCC_ST_DPE   15

// Reset and fixed values.
`define PCC_CMD_RESET  16'h0000
`define PCC_ST_RESET   16'h0000
`define PCC_PROGIF_VAL 8'h00
`define PCC_DT_MEDIUM  2'h1

// Device select delay in clocks; unused, the decoder drives select four clocks after the frame falls.
`define PCC_DEVSEL_DLY 2'h2

`endif

// ---- rtl/pcc_pkg.sv ----
package pcc_pkg;
  typedef logic [15:0] pcc_word_t;
  typedef logic [7:0]  pcc_byte_t;
  typedef logic [3:0]  pcc_lane_t;
  typedef enum logic [1:0] {
    PCC_IDLE = 2'b00,
    PCC_WAIT = 2'b01,
    PCC_SEL  = 2'b10
  } pcc_decode_e;
endpackage

// ---- bench/pcc_host_model.sv ----
`timescale 1ns/1ps
// Host bridge side: one configuration access per call.
module pcc_host_model (
  input  wire logic        clk,
  output logic             cfg_sel,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata
);
  // Idle bus at time zero.
  initial begin
    cfg_sel = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'hFF;
    cfg_be = 4'h0;
    cfg_wdata = '0;
  end
  // Strobe is held for one edge; data is taken after the next edge.
  // Address and write data are inverted on release so a stale bus never passes for a live one.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd);
    cfg_sel = 1'b1;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(posedge clk);
    #5;
    cfg_sel = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~wd;
    @(posedge clk);
    #5;
    rd = cfg_rdata;
  endtask
endmodule

// ---- bench/pcc_config_monitor.sv ----
`timescale 1ns/1ps
module pcc_config_monitor (
  input wire logic        clk, rst, cfg_sel, cfg_wr, opt_fb2b, cycle_frame_n, claim_hit,
  input wire logic        device_select_out_n, addr_parity_err, data_parity_err, is_target,
  input wire logic        parity_error_out_oe, system_error_out_oe, io_cycle, io_claim,
  input wire logic        mem_cycle, mem_claim, fast_b2b_any_agent,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A read strobe to one dword, and a frame claimed for four clocks.
  sequence rd_s(logic [5:0] d);
    cfg_sel && !cfg_wr && cfg_addr[7:2] == d;
  endsequence
  sequence claimed_s;
    $fell(cycle_frame_n) ##0 (claim_hit && !cycle_frame_n) [*4];
  endsequence
  io_gate_a: assert property (io_claim |-> io_cycle)
    else $error("io claim without io cycle");
  mem_gate_a: assert property (mem_claim |-> mem_cycle)
    else $error("memory claim without memory cycle");
  fb2b_off_a: assert property (!opt_fb2b [*3] |-> !fast_b2b_any_agent)
    else $error("fast back-to-back open with option clear");
  serr_cause_a: assert property (system_error_out_oe |-> $past(addr_parity_err))
    else $error("system error without address parity error");
  perr_cause_a: assert property (parity_error_out_oe |-> $past(data_parity_err && is_target))
    else $error("parity line driven without target data error");
  devsel_time_a: assert property (claimed_s |-> ##[1:2] !device_select_out_n)
    else $error("device select late");
  dt_bits_a: assert property (rd_s(6'h01) |=> cfg_rdata[26:25] == 2'b01)
    else $error("decode timing field wrong");
  cmd_zero_a: assert property (rd_s(6'h01) |=> cfg_rdata[15:10] == '0 && cfg_rdata[5:3] == '0)
    else $error("fixed command bits not zero");
  rev_read_a: assert property (rd_s(6'h02) |=> cfg_rdata[31:8] == '0)
    else $error("programming interface not zero");
endmodule
bind pcc_config_regs pcc_config_monitor u_mon (.clk(clk), .rst(rst), .cfg_sel(cfg_sel),
  .cfg_wr(cfg_wr), .opt_fb2b(opt_fb2b), .cycle_frame_n(cycle_frame_n), .claim_hit(claim_hit),
  .device_select_out_n(device_select_out_n), .addr_parity_err(addr_parity_err),
  .data_parity_err(data_parity_err), .is_target(is_target), .io_cycle(io_cycle),
  .parity_error_out_oe(parity_error_out_oe), .system_error_out_oe(system_error_out_oe),
  .io_claim(io_claim), .mem_cycle(mem_cycle), .mem_claim(mem_claim), .cfg_addr(cfg_addr),
  .fast_b2b_any_agent(fast_b2b_any_agent), .cfg_rdata(cfg_rdata));

// ---- bench/pcc_config_command_status_tb.sv ----
`timescale 1ns/1ps
module pcc_config_command_status_tb;
  import pcc_pkg::*;
  localparam logic [15:0] VEND = 16'h1234; // Arbitrary neutral value.
  localparam logic [15:0] DEVC = 16'h5678; // Arbitrary neutral value.
  localparam logic [7:0]  REV  = 8'h5A;
  logic        clk, rst, ee_present, ee_valid, opt_fb2b, opt_pm, cycle_frame_n, claim_hit;
  logic        addr_parity_err, data_parity_err, is_target, is_master, parity_error_line_n;
  logic        master_abort_evt, target_abort_rx_evt, target_abort_tx_evt, io_cycle, mem_cycle;
  logic        cfg_sel, cfg_wr, device_select_out_n, perr_n, perr_oe, serr_n, serr_oe;
  logic        io_claim, mem_claim, master_enable, fast_b2b_allowed, fast_b2b_any_agent;
  logic [7:0]  cfg_addr;
  pcc_lane_t   cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  pcc_word_t   ee_vendor, ee_device;
  int          miscompares, n_checks;
  pcc_config_regs #(.DEF_VENDOR(VEND), .DEF_DEVICE(DEVC), .REVISION_VAL(REV)) u_pcc_config_regs (
    .clk(clk), .rst(rst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .ee_present(ee_present), .ee_valid(ee_valid),
    .ee_vendor(ee_vendor), .ee_device(ee_device), .opt_fb2b(opt_fb2b), .opt_pm(opt_pm),
    .cycle_frame_n(cycle_frame_n), .claim_hit(claim_hit), .device_select_out_n(device_select_out_n),
    .addr_parity_err(addr_parity_err), .data_parity_err(data_parity_err), .is_target(is_target),
    .is_master(is_master), .parity_error_line_n(parity_error_line_n), .parity_error_out_n(perr_n),
    .parity_error_out_oe(perr_oe), .system_error_out_n(serr_n), .system_error_out_oe(serr_oe),
    .master_abort_evt(master_abort_evt), .target_abort_rx_evt(target_abort_rx_evt),
    .target_abort_tx_evt(target_abort_tx_evt), .io_cycle(io_cycle), .mem_cycle(mem_cycle),
    .io_claim(io_claim), .mem_claim(mem_claim), .master_enable(master_enable),
    .fast_b2b_allowed(fast_b2b_allowed), .fast_b2b_any_agent(fast_b2b_any_agent));
  pcc_host_model u_pcc_host_model (.clk(clk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  // Inputs always move 5 ns after an edge, clear of the sampling point.
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_pcc_host_model.acc(1'b0, a, 4'hF, 32'h0, rd);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [3:0] be, input logic [31:0] d);
    u_pcc_host_model.acc(1'b1, 8'h04, be, d, rd);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Clock, and a watchdog well beyond the fewer than one hundred cycles the tests need.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
  // Main sequence: identity, command masking, flags, parity, options, select, reload.
  initial begin
    {ee_present, ee_valid, opt_fb2b, opt_pm, claim_hit, addr_parity_err, data_parity_err} = '0;
    {is_target, is_master, master_abort_evt, target_abort_rx_evt, target_abort_tx_evt} = '0;
    {io_cycle, mem_cycle, cycle_frame_n, parity_error_line_n} = 4'hF;
    ee_vendor = 16'hA5C3;
    ee_device = 16'h3C5A;
    miscompares = 0;
    n_checks = 0;
    rst = 1'b1;
    tk(2);
    rst = 1'b0;
    rdc(8'h00, {DEVC, VEND});
    rdc(8'h04, 32'h0200_0000);
    rdc(8'h08, {24'h0, REV});
    wr(4'hF, 32'hFFFF_FFFF);
    rdc(8'h04, 32'h0200_0147);
    chk(master_enable, 1'b1);
    wr(4'h3, 32'h1);
    chk({io_claim, mem_claim, master_enable}, 3'b100);
    wr(4'h3, 32'h2);
    chk({io_claim, mem_claim}, 2'b01);
    wr(4'h3, 32'h0104);
    addr_parity_err = 1'b1;
    tk(1);
    addr_parity_err = 1'b0;
    chk(serr_oe, 1'b1);
    {is_target, data_parity_err} = 2'b11;
    tk(1);
    {is_target, data_parity_err} = 2'b00;
    chk(perr_oe, 1'b0);
    {master_abort_evt, target_abort_rx_evt, target_abort_tx_evt} = 3'b111;
    tk(1);
    {master_abort_evt, target_abort_rx_evt, target_abort_tx_evt} = 3'b000;
    rdc(8'h04, 32'hFA00_0104);
    wr(4'hC, 32'h16FF_0000);
    rdc(8'h04, 32'hEA00_0104);
    wr(4'hC, 32'hFFFF_0000);
    rdc(8'h04, 32'h0200_0104);
    wr(4'h3, 32'h0144);
    {is_target, data_parity_err} = 2'b11;
    tk(1);
    {is_target, data_parity_err} = 2'b00;
    chk(perr_oe, 1'b1);
    rdc(8'h04, 32'h8200_0144);
    {is_master, parity_error_line_n} = 2'b10;
    tk(3);
    parity_error_line_n = 1'b1;
    tk(3);
    is_master = 1'b0;
    rdc(8'h04, 32'h8300_0144);
    wr(4'h4, 32'hFFFF_0000);
    rdc(8'h04, 32'h8300_0144);
    {opt_fb2b, opt_pm} = 2'b11;
    tk(3);
    wr(4'hF, 32'hFFFF_0200);
    rdc(8'h04, 32'h0290_0200);
    chk({fast_b2b_allowed, fast_b2b_any_agent}, 2'b11);
    opt_fb2b = 1'b0;
    tk(3);
    rdc(8'h04, 32'h0210_0000);
    chk({fast_b2b_allowed, fast_b2b_any_agent}, 2'b00);
    {cycle_frame_n, claim_hit} = 2'b01;
    tk(6);
    chk(device_select_out_n, 1'b0);
    {cycle_frame_n, claim_hit} = 2'b10;
    {ee_present, ee_valid} = 2'b11;
    rst = 1'b1;
    tk(2);
    rst = 1'b0;
    tk(4);
    rdc(8'h00, {ee_device, ee_vendor});
    rdc(8'h04, 32'h0210_0000);
    give_verdict;
  end
endmodule
